/* design/foc_sup_map.svh */
// register map, field positions, reset values and timing counts of the supervisor
`ifndef FOC_SUP_MAP_SVH
`define FOC_SUP_MAP_SVH
`define SYS_CLK_HZ 20000000
`define NOLOAD_TIME_US 10000
`define NOLOAD_CYCLES (`NOLOAD_TIME_US * (`SYS_CLK_HZ / 1000000))
// register word indices, byte address is index times four
`define IDX_SPEED 5'h00
`define IDX_LOOP1 5'h01
`define IDX_LOOP2 5'h02
`define IDX_FIELD 5'h03
`define IDX_FWRATIO 5'h04
`define IDX_FWTHR 5'h05
`define IDX_DEBUG 5'h06
`define IDX_VBASE 5'h07
`define IDX_VLOW 5'h08
`define IDX_VHIGH 5'h09
`define IDX_RECOV 5'h0A
`define IDX_MLTHR 5'h0B
`define IDX_IBASE 5'h0C
`define IDX_MAXSPD 5'h0D
`define IDX_MAXPWR 5'h0E
`define IDX_ILIM 5'h0F
`define IDX_BRKTHR 5'h10
`define IDX_FAULT 5'h11
`define IDX_STATE 5'h12
`define IDX_LAST_CFG 5'h10
// field positions
`define STOPOPT_BIT 2
`define FWEN_BIT 0
`define CLR_BIT 0
`define UVSEL_BIT 0
`define OVSEL_BIT 1
`define F_UV 0
`define F_OV 1
`define F_ML 2
`define F_LOCK 3
// reset values
`define RST_ZERO 32'h0000_0000
`define RST_VFULL 32'h0000_FFFF
// arithmetic constants, invalid hall codes and response codes
`define IQ15_FULL 32'h0000_7FFF
`define PCT_FULL 32'h0000_0064
`define LOW_DIV 32'h0000_0004
`define HIGH_NUM 32'h0000_0003
`define HIGH_DEN 32'h0000_0005
`define HALL_BAD_LO 3'h0
`define HALL_BAD_HI 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* design/foc_sup_pkg.sv */
// types shared by the supervisor files
package foc_sup_pkg;
  typedef enum logic [1:0] {
    MODE_SPEED = 2'h0,
    MODE_POWER = 2'h1,
    MODE_TORQUE = 2'h2,
    MODE_VOLTAGE = 2'h3
  } ctrl_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RUN = 3'h1,
    ST_BRK_DEC = 3'h2,
    ST_BRK_HOLD = 3'h3,
    ST_STOP_DEC = 3'h4,
    ST_STOP_BRK = 3'h5,
    ST_FAULT = 3'h6
  } sup_state_e;
  typedef logic [15:0] word16_t;
endpackage

/* design/lead_angle_rotator.sv */
// lead angle rotation of the modulation index into vq and vd
`timescale 1ns/1ps
module lead_angle_rotator #(
  parameter int ANGLE_W = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [14:0] i_mag,
  input wire logic [ANGLE_W-1:0] i_angle,
  output foc_sup_pkg::word16_t o_vq,
  output foc_sup_pkg::word16_t o_vd
);
  import foc_sup_pkg::*;

  generate
    if (ANGLE_W != 3) begin : g_bad
      $error("lead angle table holds eight steps");
    end
  endgenerate

  // 5 degree steps, q15
  function automatic logic [15:0] cos_q15(input logic [2:0] a);
    unique case (a)
      3'h0: cos_q15 = 16'h7FFF;
      3'h1: cos_q15 = 16'h7F82;
      3'h2: cos_q15 = 16'h7E0E;
      3'h3: cos_q15 = 16'h7BA3;
      3'h4: cos_q15 = 16'h7847;
      3'h5: cos_q15 = 16'h7401;
      3'h6: cos_q15 = 16'h6EDA;
      3'h7: cos_q15 = 16'h68DA;
    endcase
  endfunction

  function automatic logic [15:0] sin_q15(input logic [2:0] a);
    unique case (a)
      3'h0: sin_q15 = 16'h0000;
      3'h1: sin_q15 = 16'h0B28;
      3'h2: sin_q15 = 16'h163A;
      3'h3: sin_q15 = 16'h2121;
      3'h4: sin_q15 = 16'h2BC7;
      3'h5: sin_q15 = 16'h3618;
      3'h6: sin_q15 = 16'h4000;
      3'h7: sin_q15 = 16'h496B;
    endcase
  endfunction

  function automatic logic [15:0] mul_q15(input logic [14:0] m, input logic [15:0] k);
    logic [31:0] p;
    p = {17'h0, m} * {16'h0, k};
    mul_q15 = p[30:15];
  endfunction

  word16_t vq_reg, vq_next, vd_reg, vd_next;

  always_comb begin
    vq_next = mul_q15(i_mag, cos_q15(i_angle)); // [R16]
    vd_next = mul_q15(i_mag, sin_q15(i_angle)); // [R16]
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      vq_reg <= 16'h0000;
      vd_reg <= 16'h0000;
    end else if (i_ce) begin
      vq_reg <= vq_next;
      vd_reg <= vd_next;
    end
  end

  assign o_vq = vq_reg;
  assign o_vd = vd_reg;
endmodule

/* design/foc_mode_and_fault_supervisor.sv */
// mode selection, fault supervision and stop handling for a hall sensored motor controller
//
// Overview of operation
// [R1] speed target equals command times max over 32767
// [R2] nonzero reference starts commutation, zero stops
// [R3] fault clear bit wipes all fault flags
// [R4] low supply limit within quarter base; below faults
// [R5] high supply limit 60 to 100 percent; above faults
// [R6] undervoltage fault auto clears or latches
// [R7] overvoltage fault auto clears or latches
// [R8] phase current below threshold raises missing load
// [R9] hall code zero or seven is invalid
// [R10] invalid hall shown as lock fault
// [R11] every mode uses one q15 reference field
// [R12] mode 2 regulates torque current over current base
// [R13] mode 1 regulates power over max power
// [R14] mode 0 regulates speed over max speed
// [R15] mode 3 applies reference as modulation index
// [R16] voltage mode rotates by lead angle
// [R17] field weaken enable allows negative id
// [R18] id to iq ratio capped by setting
// [R19] id only when modulation squared exceeds threshold
// [R20] iq limit keeps id and iq inside circle
// [R21] low side brake stop with speed threshold
// [R22] fault disables outputs until clear and restart
// [R23] brake decelerates to threshold then holds
`timescale 1ns/1ps
`include "foc_sup_map.svh"
module foc_mode_and_fault_supervisor #(
  parameter int ADDR_W = 8,
  parameter int NOLOAD_CYCLES = `NOLOAD_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [2:0] i_hall,
  input wire logic i_brake,
  input wire foc_sup_pkg::word16_t i_bus_volt,
  input wire foc_sup_pkg::word16_t i_phase_curr,
  input wire foc_sup_pkg::word16_t i_speed_meas,
  input wire foc_sup_pkg::word16_t i_mod_sq,
  output logic o_outputs_en,
  output logic o_commutate,
  output logic o_lowside_brake,
  output foc_sup_pkg::ctrl_mode_e o_ctrl_mode,
  output foc_sup_pkg::word16_t o_target,
  output foc_sup_pkg::word16_t o_vq,
  output foc_sup_pkg::word16_t o_vd,
  output foc_sup_pkg::word16_t o_id_ref,
  output foc_sup_pkg::word16_t o_iq_limit,
  output logic [3:0] o_fault
);
  import foc_sup_pkg::*;

  generate
    if (ADDR_W < 7 || NOLOAD_CYCLES < 1 || NOLOAD_CYCLES > 16777215) begin : g_bad
      $error("address width or missing load count out of range");
    end
  endgenerate

  function automatic logic [15:0] scale(input logic [14:0] r, input logic [15:0] b);
    logic [31:0] p;
    p = {17'h0, r} * {16'h0, b};
    scale = 16'(p / `IQ15_FULL);
  endfunction

  function automatic logic [31:0] sq(input logic [14:0] x);
    sq = {17'h0, x} * {17'h0, x};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] hall_m_reg, hall_s_reg;
  logic brake_m_reg, brake_s_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      hall_m_reg <= 3'h0;
      hall_s_reg <= 3'h0;
      brake_m_reg <= 1'b0;
      brake_s_reg <= 1'b0;
    end else if (i_ce) begin
      hall_m_reg <= i_hall;
      hall_s_reg <= hall_m_reg;
      brake_m_reg <= i_brake;
      brake_s_reg <= brake_m_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave and configuration words
  logic [31:0] cfg_reg [0:16];
  logic [31:0] cfg_next [0:16];
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, wr_word;
  logic clr_reg, clr_next;
  logic [4:0] wr_idx, rd_idx;
  logic wr_hi, rd_hi;
  logic [3:0] fault_reg, fault_next;
  sup_state_e state_reg, state_next;
  word16_t iq_lim_reg, iq_lim_next, id_mag_reg, id_mag_next;

  assign wr_idx = aw_addr_reg[6:2];
  assign rd_idx = i_araddr[6:2];
  assign wr_hi = |(aw_addr_reg >> 7);
  assign rd_hi = |(i_araddr >> 7);
  assign wr_word = merge(cfg_reg[wr_idx > `IDX_LAST_CFG ? 5'h00 : wr_idx], w_data_reg, w_strb_reg);

  always_comb begin
    cfg_next = cfg_reg;
    aw_full_next = aw_full_reg | (i_awvalid & awready_reg);
    w_full_next = w_full_reg | (i_wvalid & wready_reg);
    aw_addr_next = (i_awvalid & awready_reg) ? i_awaddr : aw_addr_reg;
    w_data_next = (i_wvalid & wready_reg) ? i_wdata : w_data_reg;
    w_strb_next = (i_wvalid & wready_reg) ? i_wstrb : w_strb_reg;
    bvalid_next = bvalid_reg & ~i_bready;
    bresp_next = bresp_reg;
    clr_next = 1'b0;
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `RESP_OKAY;
      if (wr_hi || wr_idx > `IDX_STATE) begin
        bresp_next = `RESP_SLVERR;
      end else if (wr_idx == `IDX_DEBUG) begin
        clr_next = wr_word[`CLR_BIT]; // [R3]
      end else if (wr_idx == `IDX_VLOW) begin
        if ({16'h0, wr_word[15:0]} * `LOW_DIV <= {16'h0, cfg_reg[`IDX_VBASE][15:0]}) begin
          cfg_next[wr_idx] = {16'h0, wr_word[15:0]}; // [R4]
        end else begin
          bresp_next = `RESP_SLVERR;
        end
      end else if (wr_idx == `IDX_VHIGH) begin
        if ({16'h0, wr_word[15:0]} * `HIGH_DEN >= {16'h0, cfg_reg[`IDX_VBASE][15:0]} * `HIGH_NUM
            && wr_word[15:0] <= cfg_reg[`IDX_VBASE][15:0]) begin
          cfg_next[wr_idx] = {16'h0, wr_word[15:0]}; // [R5]
        end else begin
          bresp_next = `RESP_SLVERR;
        end
      end else if (wr_idx <= `IDX_LAST_CFG) begin
        cfg_next[wr_idx] = wr_word;
      end
    end
    awready_next = ~aw_full_next;
    wready_next = ~w_full_next;
    rvalid_next = rvalid_reg & ~i_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (i_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `RESP_OKAY;
      rdata_next = 32'h0000_0000;
      if (rd_hi || rd_idx > `IDX_STATE) begin
        rresp_next = `RESP_SLVERR;
      end else if (rd_idx == `IDX_FAULT) begin
        rdata_next = {28'h0, fault_reg};
      end else if (rd_idx == `IDX_STATE) begin
        rdata_next = {iq_lim_reg, id_mag_reg[12:0], state_reg};
      end else if (rd_idx != `IDX_DEBUG) begin
        rdata_next = cfg_reg[rd_idx];
      end
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      for (int i = 0; i <= 16; i++) begin
        cfg_reg[i] <= (i == 7 || i == 9) ? `RST_VFULL : `RST_ZERO;
      end
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      clr_reg <= 1'b0;
    end else if (i_ce) begin
      cfg_reg <= cfg_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      clr_reg <= clr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields
  logic [14:0] ref_w;
  ctrl_mode_e mode_w;
  logic running, any_fault, hall_bad, uv_cond, ov_cond, ml_cond, fw_act;
  logic [23:0] ml_cnt_reg, ml_cnt_next;

  assign ref_w = cfg_reg[`IDX_SPEED][14:0]; // [R11]
  assign mode_w = ctrl_mode_e'(cfg_reg[`IDX_LOOP1][1:0]);
  assign running = state_reg == ST_RUN || state_reg == ST_BRK_DEC || state_reg == ST_STOP_DEC;
  assign any_fault = |fault_reg;
  assign hall_bad = hall_s_reg == `HALL_BAD_LO || hall_s_reg == `HALL_BAD_HI; // [R9]
  assign uv_cond = i_bus_volt < cfg_reg[`IDX_VLOW][15:0]; // [R4]
  assign ov_cond = i_bus_volt > cfg_reg[`IDX_VHIGH][15:0]; // [R5]
  assign ml_cond = {16'h0, i_phase_curr} * `PCT_FULL
                   < {25'h0, cfg_reg[`IDX_MLTHR][6:0]} * {16'h0, cfg_reg[`IDX_IBASE][15:0]};
  assign fw_act = cfg_reg[`IDX_FIELD][`FWEN_BIT] && running && mode_w != MODE_VOLTAGE
                  && i_mod_sq > cfg_reg[`IDX_FWTHR][15:0]; // [R17] [R19]

  ////////////////////////////////////////////////////////////////////////////
  // fault flags, set wins over clear
  always_comb begin
    fault_next = fault_reg;
    if (clr_reg) begin
      fault_next = 4'h0; // [R3]
    end
    if (!cfg_reg[`IDX_RECOV][`UVSEL_BIT] && !uv_cond) begin
      fault_next[`F_UV] = 1'b0; // [R6]
    end
    if (!cfg_reg[`IDX_RECOV][`OVSEL_BIT] && !ov_cond) begin
      fault_next[`F_OV] = 1'b0; // [R7]
    end
    if (uv_cond) begin
      fault_next[`F_UV] = 1'b1; // [R4]
    end
    if (ov_cond) begin
      fault_next[`F_OV] = 1'b1; // [R5]
    end
    ml_cnt_next = (running && ml_cond) ? ml_cnt_reg + 24'h000001 : 24'h000000;
    if (running && ml_cond && ml_cnt_reg >= 24'(NOLOAD_CYCLES - 1)) begin
      fault_next[`F_ML] = 1'b1; // [R8]
      ml_cnt_next = ml_cnt_reg;
    end
    if (running && hall_bad) begin
      fault_next[`F_LOCK] = 1'b1; // [R10]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      fault_reg <= 4'h0;
      ml_cnt_reg <= 24'h000000;
    end else if (i_ce) begin
      fault_reg <= fault_next;
      ml_cnt_reg <= ml_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run, brake and stop sequencing
  logic spd_at_brk;
  assign spd_at_brk = i_speed_meas <= cfg_reg[`IDX_BRKTHR][15:0];

  always_comb begin
    state_next = state_reg;
    if (any_fault) begin
      state_next = ST_FAULT; // [R22]
    end else begin
      unique case (state_reg)
        ST_IDLE: if (ref_w != 15'h0) state_next = ST_RUN; // [R2]
        ST_RUN: begin
          if (brake_s_reg) begin
            state_next = ST_BRK_DEC; // [R23]
          end else if (ref_w == 15'h0) begin
            state_next = cfg_reg[`IDX_LOOP1][`STOPOPT_BIT] ? ST_STOP_DEC : ST_IDLE; // [R2] [R21]
          end
        end
        ST_BRK_DEC: begin
          if (!brake_s_reg) begin
            state_next = ST_RUN;
          end else if (spd_at_brk) begin
            state_next = ST_BRK_HOLD; // [R23]
          end
        end
        ST_BRK_HOLD: if (!brake_s_reg) state_next = (ref_w != 15'h0) ? ST_RUN : ST_IDLE;
        ST_STOP_DEC: begin
          if (ref_w != 15'h0) begin
            state_next = ST_RUN;
          end else if (spd_at_brk) begin
            state_next = ST_STOP_BRK; // [R21]
          end
        end
        ST_STOP_BRK: begin
          if (ref_w != 15'h0) begin
            state_next = ST_RUN;
          end else if (i_speed_meas == 16'h0000) begin
            state_next = ST_IDLE;
          end
        end
        ST_FAULT: if (ref_w == 15'h0) state_next = ST_IDLE; // [R22]
        default: state_next = ST_FAULT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // targets and field weakening
  logic outen_next, comm_next, lsb_next;
  word16_t target_reg, target_next, id_ref_next;
  logic [31:0] id2, iq2, lim2, iq2_up;
  logic [15:0] fw_cap;
  logic [14:0] ilim_w;

  assign ilim_w = cfg_reg[`IDX_ILIM][14:0];
  assign id2 = sq(id_mag_reg[14:0]);
  assign iq2 = sq(iq_lim_reg[14:0]);
  assign iq2_up = sq(iq_lim_reg[14:0] + 15'h0001);
  assign lim2 = sq(ilim_w);
  assign fw_cap = 16'(({16'h0, cfg_reg[`IDX_FWRATIO][15:0]} * {16'h0, iq_lim_reg}) >> 15);

  always_comb begin
    outen_next = state_next != ST_IDLE && state_next != ST_FAULT; // [R22]
    comm_next = state_next == ST_RUN || state_next == ST_BRK_DEC || state_next == ST_STOP_DEC;
    lsb_next = state_next == ST_BRK_HOLD || state_next == ST_STOP_BRK; // [R21] [R23]
    target_next = 16'h0000;
    if (state_next == ST_BRK_DEC) begin
      target_next = cfg_reg[`IDX_BRKTHR][15:0]; // [R23]
    end else if (state_next == ST_RUN) begin
      unique case (mode_w)
        MODE_SPEED: target_next = scale(ref_w, cfg_reg[`IDX_MAXSPD][15:0]); // [R1] [R14]
        MODE_POWER: target_next = scale(ref_w, cfg_reg[`IDX_MAXPWR][15:0]); // [R13]
        MODE_TORQUE: target_next = scale(ref_w, cfg_reg[`IDX_IBASE][15:0]); // [R12]
        MODE_VOLTAGE: target_next = {1'b0, ref_w}; // [R15]
      endcase
    end
    id_mag_next = id_mag_reg;
    if (fw_act && id_mag_reg < fw_cap) begin
      id_mag_next = id_mag_reg + 16'h0001; // [R17]
    end else if (fw_act && id_mag_reg > fw_cap) begin
      id_mag_next = fw_cap; // [R18]
    end else if (!fw_act && id_mag_reg != 16'h0000) begin
      id_mag_next = id_mag_reg - 16'h0001;
    end
    id_ref_next = 16'h0000 - id_mag_next;
    iq_lim_next = iq_lim_reg;
    if (id2 + iq2 > lim2 && iq_lim_reg != 16'h0000) begin
      iq_lim_next = iq_lim_reg - 16'h0001; // [R20]
    end else if (iq_lim_reg[14:0] < ilim_w && id2 + iq2_up <= lim2) begin
      iq_lim_next = iq_lim_reg + 16'h0001; // [R20]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      o_outputs_en <= 1'b0;
      o_commutate <= 1'b0;
      o_lowside_brake <= 1'b0;
      o_ctrl_mode <= MODE_SPEED;
      target_reg <= 16'h0000;
      id_mag_reg <= 16'h0000;
      iq_lim_reg <= 16'h0000;
      o_id_ref <= 16'h0000;
    end else if (i_ce) begin
      state_reg <= state_next;
      o_outputs_en <= outen_next;
      o_commutate <= comm_next;
      o_lowside_brake <= lsb_next;
      o_ctrl_mode <= mode_w;
      target_reg <= target_next;
      id_mag_reg <= id_mag_next;
      iq_lim_reg <= iq_lim_next;
      o_id_ref <= id_ref_next;
    end
  end

  lead_angle_rotator #(
    .ANGLE_W(3)
  ) u_rot (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_mag((mode_w == MODE_VOLTAGE && comm_next) ? ref_w : 15'h0000), // [R15] [R16]
    .i_angle(cfg_reg[`IDX_LOOP2][2:0]),
    .o_vq(o_vq),
    .o_vd(o_vd)
  );

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_target = target_reg;
  assign o_iq_limit = iq_lim_reg;
  assign o_fault = fault_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn || !i_ce);

  sequence s_run_brake;
    state_reg == ST_RUN && brake_s_reg && !any_fault;
  endsequence
  sequence s_brake_dec;
    state_reg == ST_BRK_DEC ##0 o_target == $past(cfg_reg[`IDX_BRKTHR][15:0]);
  endsequence

  property p_fault_off;
    any_fault |=> !o_outputs_en && state_reg == ST_FAULT;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("outputs on under fault"); // [R22]
  property p_start;
    state_reg == ST_IDLE && ref_w != 15'h0 && !any_fault |=> o_commutate;
  endproperty
  a_start: assert property (p_start) else $error("no start on nonzero ref"); // [R2]
  property p_clear;
    clr_reg && !uv_cond && !ov_cond && !running |=> fault_reg == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("faults not cleared"); // [R3]
  property p_uv;
    uv_cond |=> fault_reg[`F_UV];
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage missed"); // [R4]
  property p_ov;
    ov_cond |=> fault_reg[`F_OV];
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage missed"); // [R5]
  property p_uv_auto;
    !cfg_reg[`IDX_RECOV][`UVSEL_BIT] && !uv_cond |=> !fault_reg[`F_UV];
  endproperty
  a_uv_auto: assert property (p_uv_auto) else $error("undervoltage not auto cleared"); // [R6]
  property p_ov_latch;
    cfg_reg[`IDX_RECOV][`OVSEL_BIT] && fault_reg[`F_OV] && !clr_reg |=> fault_reg[`F_OV];
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("overvoltage latch lost"); // [R7]
  property p_hall;
    running && hall_bad |=> fault_reg[`F_LOCK] ##1 !o_outputs_en;
  endproperty
  a_hall: assert property (p_hall) else $error("invalid hall not locked"); // [R9]
  property p_speed_target;
    state_reg == ST_RUN && $past(mode_w) == MODE_SPEED
      |-> o_target == scale($past(ref_w), $past(cfg_reg[`IDX_MAXSPD][15:0]));
  endproperty
  a_speed_target: assert property (p_speed_target) else $error("speed target wrong"); // [R1]
  property p_brake;
    s_run_brake |=> s_brake_dec;
  endproperty
  a_brake: assert property (p_brake) else $error("brake not entered"); // [R23]
  property p_circle;
    id2 + iq2 > lim2 && iq_lim_reg != 16'h0000 |=> iq_lim_reg == $past(iq_lim_reg) - 16'h0001;
  endproperty
  a_circle: assert property (p_circle) else $error("iq limit not reduced"); // [R20]
  property p_fw_gate;
    id_mag_reg == 16'h0000 && !fw_act |=> id_mag_reg == 16'h0000;
  endproperty
  a_fw_gate: assert property (p_fw_gate) else $error("id driven without weakening"); // [R19]
endmodule

/* test/hall_motor_model.sv */
// hall sensor and phase current model of the motor side
`timescale 1ns/1ps
module hall_motor_model (
  input wire logic i_sys_clk,
  input wire logic i_run,
  input wire logic i_bad,
  output logic [2:0] o_hall,
  output foc_sup_pkg::word16_t o_phase_curr,
  output foc_sup_pkg::word16_t o_speed_meas
);
  import foc_sup_pkg::*;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int idx = 0;
  always @(posedge i_sys_clk) begin
    if (i_run) idx <= (idx + 1) % 6;
  end
  // a broken sensor harness reads all ones
  assign o_hall = i_bad ? 3'h7 : seq[idx];
  assign o_phase_curr = i_run ? 16'h0400 : 16'h0000;
  assign o_speed_meas = i_run ? 16'h0100 : 16'h0000;
endmodule

/* test/foc_mode_and_fault_supervisor_tb.sv */
// self-checking bench for the mode and fault supervisor
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module foc_mode_and_fault_supervisor_tb;
  import foc_sup_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, bad = 0, brk = 0;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv, en, comm, lsb;
  logic [1:0] br, rr, rs, mode;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, rdat;
  logic [2:0] hall;
  word16_t volt = 16'h8000, pc, spd, tgt, vq, vd, idr, iql;
  word16_t exp_t [4] = '{16'h0031, 16'h0063, 16'h0004, 16'h3FFF};
  logic [3:0] flt;
  int n_fail = 0, n_checks = 0, cyc = 0;
  foc_mode_and_fault_supervisor #(.NOLOAD_CYCLES(8)) foc_mode_and_fault_supervisor_inst (
    .i_sys_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_awvalid(awv), .o_awready(aw_rdy),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(w_rdy), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(brdy), .o_bresp(br), .i_arvalid(arv), .o_arready(ar_rdy),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rrdy), .o_rdata(rdat), .o_rresp(rr),
    .i_hall(hall), .i_brake(brk), .i_bus_volt(volt), .i_phase_curr(pc),
    .i_speed_meas(spd), .i_mod_sq(16'h0000), .o_outputs_en(en), .o_commutate(comm),
    .o_lowside_brake(lsb), .o_ctrl_mode(mode), .o_target(tgt), .o_vq(vq), .o_vd(vd),
    .o_id_ref(idr), .o_iq_limit(iql), .o_fault(flt));
  hall_motor_model hall_motor_model_inst (.i_sys_clk(clk), .i_run(comm), .i_bad(bad),
    .o_hall(hall), .o_phase_curr(pc), .o_speed_meas(spd));
  initial forever #25 clk = ~clk;
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; brdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (o_take(aw_rdy, awv)) awv <= 1'b0;
      if (o_take(w_rdy, wv)) wv <= 1'b0;
      if (bv) begin
        rs = br; brdy <= 1'b0; break;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1; ara <= a; rrdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (o_take(ar_rdy, arv)) arv <= 1'b0;
      if (rv) begin
        rd = rdat; rs = rr; rrdy <= 1'b0; break;
      end
    end
  endtask
  function automatic logic o_take(input logic r, input logic v);
    return r && v;
  endfunction
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    axr(8'h1C); `CHK("base volt", 32'h0000FFFF, rd)
    axr(8'h4C); `CHK("unmapped", 2'h2, rs)
    axw(8'h20, 32'h5000); `CHK("low refused", 2'h2, rs)
    axw(8'h20, 32'h3FFF); `CHK("low ok", 2'h0, rs)
    axw(8'h24, 32'h9000); `CHK("high refused", 2'h2, rs)
    axw(8'h24, 32'hA000); `CHK("high ok", 2'h0, rs)
    axw(8'h30, 10); axw(8'h34, 100); axw(8'h38, 200); axw(8'h3C, 32'h20);
    axw(8'h00, 32'h3FFF);
    for (int m = 0; m < 4; m++) begin
      axw(8'h04, m);
      repeat (4) @(posedge clk);
      `CHK("target", exp_t[m], tgt)
      `CHK("commutate", 1'b1, comm)
      `CHK("mode", m[1:0], mode)
    end
    axw(8'h08, 6);
    repeat (3) @(posedge clk);
    `CHK("vq", 16'h376C, vq)
    `CHK("vd", 16'h1FFF, vd)
    `CHK("iq limit", 16'h0020, iql)
    `CHK("id ref", 16'h0000, idr)
    $display("test modes done");
    volt <= 16'h1000;
    repeat (3) @(posedge clk);
    `CHK("uv fault", 4'h1, flt)
    `CHK("outputs off", 1'b0, en)
    volt <= 16'h8000;
    repeat (3) @(posedge clk);
    `CHK("uv auto clear", 4'h0, flt)
    axw(8'h00, 0); axw(8'h00, 32'h3FFF);
    repeat (4) @(posedge clk);
    `CHK("restart", 1'b1, comm)
    axw(8'h30, 32'h4000); axw(8'h2C, 50);
    repeat (12) @(posedge clk);
    `CHK("missing load", 4'h4, flt)
    axw(8'h00, 0); axw(8'h2C, 0); axw(8'h18, 1);
    axw(8'h00, 32'h3FFF);
    repeat (4) @(posedge clk);
    axw(8'h40, 32'h100); brk <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("brake hold", 1'b1, lsb)
    brk <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("brake release", 1'b1, comm)
    axw(8'h04, 32'h7); axw(8'h00, 0);
    repeat (2) @(posedge clk);
    `CHK("stop brake", 1'b1, lsb)
    axw(8'h00, 32'h3FFF);
    repeat (4) @(posedge clk);
    $display("test stops done");
    bad <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("hall lock", 1'b1, flt[3])
    bad <= 1'b0;
    axw(8'h28, 2); volt <= 16'hB000;
    repeat (3) @(posedge clk);
    volt <= 16'h8000;
    repeat (3) @(posedge clk);
    `CHK("ov latched", 1'b1, flt[1])
    axw(8'h00, 0); axw(8'h18, 1);
    repeat (3) @(posedge clk);
    `CHK("cleared", 4'h0, flt)
    $display("test faults done");
    summarize();
  end
endmodule
